// file: include/evg_pkg.sv
// Operation
// [R1] Add load angle to commutation angle in the direction of motion.
// [R2] Load angle is zero unless the compensation enable bit is set.
// [R3] Maximum load angle register bounds the angle; resets to 255 (90 degrees).
// [R4] Zero up to minimum, linear up to minimum plus span, maximum above.
// [R5] Thresholds compare against filtered encoder velocity, not ramp velocity.
// [R6] Software keeps lag angle plus load angle below 180 degrees (511).
// [R7] Raw encoder velocity is readable in microsteps per second.
// [R8] Filtered velocity is readable and feeds the load angle computation.
// [R9] Eight-bit sample wait sets cycles between filter samples.
// [R10] Software sets sample wait above 32 with an incremental encoder.
// [R11] Absolute encoder uses the serial request period as sample wait.
// [R12] Filter: mean minus mean shifted by exponent plus raw shifted by exponent.
// [R13] Sixteen-bit update period refreshes high velocities; incremental minimum 256.
// [R14] Absolute encoder update period follows the encoder request rate.
// [R15] Low velocities are recomputed on AB transitions, not on the period.
// [R16] No AB transition for idle timeout cycles raises the encoder idle event.
// [R17] Linear region: maximum times velocity above minimum, divided by span.
package evg_pkg;

  localparam int unsigned CLK_FREQ_HZ = 100000000;
  localparam logic [47:0] CLK_HZ_W48  = 48'(CLK_FREQ_HZ);

  localparam logic [7:0] OFS_ENCODER_INPUT_CONFIG    = 8'h07;
  localparam logic [7:0] OFS_LOAD_ANGLE_MAXIMUM      = 8'h1c;
  localparam logic [7:0] OFS_EMF_VELOCITY_MINIMUM    = 8'h60;
  localparam logic [7:0] OFS_EMF_VELOCITY_SPAN       = 8'h61;
  localparam logic [7:0] OFS_ENCODER_IDLE_TIMEOUT    = 8'h62;
  localparam logic [7:0] OFS_VELOCITY_FILTER_CONFIG  = 8'h63;
  localparam logic [7:0] OFS_RAW_ENCODER_VELOCITY    = 8'h65;
  localparam logic [7:0] OFS_FILTERED_ENC_VELOCITY   = 8'h66;
  localparam logic [7:0] OFS_SERIAL_REQUEST_PERIOD   = 8'h70;
  localparam logic [7:0] OFS_ENCODER_STATUS          = 8'h71;

  localparam logic [7:0]  RST_LOAD_ANGLE_MAXIMUM     = 8'hff;
  localparam logic [31:0] RST_ENCODER_INPUT_CONFIG   = 32'h0000_0000;
  localparam logic [31:0] RST_EMF_VELOCITY_MINIMUM   = 32'h0000_0000;
  localparam logic [31:0] RST_EMF_VELOCITY_SPAN      = 32'h0000_0000;
  localparam logic [31:0] RST_ENCODER_IDLE_TIMEOUT   = 32'h0000_0000;
  localparam logic [31:0] RST_VELOCITY_FILTER_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_SERIAL_REQUEST_PERIOD  = 32'h0000_0000;

  localparam int unsigned STATUS_IDLE_BIT        = 0;
  localparam logic [15:0] MIN_ABN_UPDATE_PERIOD  = 16'h0100;
  localparam logic [15:0] LOW_SPEED_EDGES        = 16'h0002;

  typedef struct packed {
    logic [29:0] reserved;
    logic        abs_encoder;
    logic        emf_comp_enable;
  } evg_enc_cfg_t;

  typedef struct packed {
    logic [15:0] velocity_update_period;
    logic [3:0]  reserved;
    logic [3:0]  filter_exponent;
    logic [7:0]  filter_sample_wait;
  } evg_filter_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } evg_reg_req_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_VEL,
    SEQ_GAMMA
  } evg_seq_t;

endpackage : evg_pkg

// file: rtl/evg_divider.sv
`timescale 1ns/1ps
// Restoring divider, one quotient bit per cycle. A zero divisor saturates the quotient.
module evg_divider #(
  parameter int unsigned W = 48
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quot
);

  logic [W-1:0]         rem;
  logic [W-1:0]         dvs;
  logic [$clog2(W):0]   cnt;
  logic [W:0]           trial;

  assign trial = {rem, quot[W-1]} - {1'b0, dvs};

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rem  <= '0;
      dvs  <= '0;
      quot <= '0;
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        rem  <= '0;
        dvs  <= den;
        quot <= num;
        cnt  <= ($clog2(W)+1)'(W);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (dvs == '0)
        begin
          quot <= '1;
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          if (!trial[W])
          begin
            rem  <= trial[W-1:0];
            quot <= {quot[W-2:0], 1'b1};
          end
          else
          begin
            rem  <= {rem[W-2:0], quot[W-1]};
            quot <= {quot[W-2:0], 1'b0};
          end
          cnt <= cnt - 1'b1;
          if (cnt == ($clog2(W)+1)'(1))
          begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

endmodule : evg_divider

// file: rtl/evg_emf_comp.sv
`timescale 1ns/1ps
module evg_emf_comp #(
  parameter int unsigned ANGLE_W = 10,
  parameter int unsigned DIV_W   = 48
) (
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  input  wire evg_pkg::evg_reg_req_t reg_req,
  output logic [31:0]                rd_data,
  input  wire logic                  enc_a,
  input  wire logic                  enc_b,
  input  wire logic                  abs_pos_valid,
  input  wire logic [31:0]           abs_pos,
  input  wire logic [ANGLE_W-1:0]    commut_angle,
  output logic [ANGLE_W-1:0]         comp_angle,
  output logic [7:0]                 load_angle,
  output logic                       encoder_idle_event
);

  logic [7:0]               load_angle_maximum;
  evg_pkg::evg_enc_cfg_t    encoder_input_config;
  logic [31:0]              emf_velocity_minimum;
  logic [31:0]              emf_velocity_span;
  logic [31:0]              encoder_idle_timeout;
  evg_pkg::evg_filter_cfg_t velocity_filter_config;
  logic [31:0]              serial_request_period;
  logic                     idle_flag;
  logic signed [31:0]       raw_encoder_velocity;
  logic signed [31:0]       filtered_encoder_velocity;

  logic [2:0]   a_sync;
  logic [2:0]   b_sync;
  logic         a_q;
  logic         b_q;
  logic [1:0]   ab_prev;
  logic         ab_edge;
  logic         step_up;
  logic [15:0]  win_cnt;
  logic [15:0]  period_eff;
  logic signed [16:0] win_delta;
  logic [15:0]  win_mag;
  logic         slow_mode;
  logic [31:0]  gap;
  logic         idle_hit;
  logic [31:0]  abs_prev;
  logic [31:0]  abs_delta;
  logic [31:0]  abs_mag;
  logic [19:0]  abs_mag_clip;
  logic [31:0]  wait_cnt;
  logic [31:0]  wait_eff;
  logic [31:0]  mean_abs;
  logic [32:0]  upper_edge;
  logic         linear_region;
  logic [7:0]   gamma_lin;
  logic         wr_en;

  logic              vel_pend;
  logic [DIV_W-1:0]  vel_num;
  logic [DIV_W-1:0]  vel_den;
  logic              vel_neg;
  logic              new_job;
  logic [DIV_W-1:0]  new_num;
  logic [DIV_W-1:0]  new_den;
  logic              new_neg;
  evg_pkg::evg_seq_t seq;
  logic              div_start;
  logic [DIV_W-1:0]  div_num;
  logic [DIV_W-1:0]  div_den;
  logic              div_busy;
  logic              div_done;
  logic [DIV_W-1:0]  div_quot;

  assign wr_en = reg_req.wr;

  // Register writes; reads of the two velocity registers have no side effect.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      load_angle_maximum     <= evg_pkg::RST_LOAD_ANGLE_MAXIMUM; // see [R3]
      encoder_input_config   <= evg_pkg::RST_ENCODER_INPUT_CONFIG;
      emf_velocity_minimum   <= evg_pkg::RST_EMF_VELOCITY_MINIMUM;
      emf_velocity_span      <= evg_pkg::RST_EMF_VELOCITY_SPAN;
      encoder_idle_timeout   <= evg_pkg::RST_ENCODER_IDLE_TIMEOUT;
      velocity_filter_config <= evg_pkg::RST_VELOCITY_FILTER_CONFIG;
      serial_request_period  <= evg_pkg::RST_SERIAL_REQUEST_PERIOD;
    end
    else if (wr_en)
    begin
      unique case (reg_req.addr)
        evg_pkg::OFS_LOAD_ANGLE_MAXIMUM:     load_angle_maximum     <= reg_req.wdata[7:0];
        evg_pkg::OFS_ENCODER_INPUT_CONFIG:   encoder_input_config   <= reg_req.wdata;
        evg_pkg::OFS_EMF_VELOCITY_MINIMUM:   emf_velocity_minimum   <= reg_req.wdata;
        evg_pkg::OFS_EMF_VELOCITY_SPAN:      emf_velocity_span      <= reg_req.wdata;
        evg_pkg::OFS_ENCODER_IDLE_TIMEOUT:   encoder_idle_timeout   <= reg_req.wdata;
        evg_pkg::OFS_VELOCITY_FILTER_CONFIG: velocity_filter_config <= reg_req.wdata;
        evg_pkg::OFS_SERIAL_REQUEST_PERIOD:  serial_request_period  <= reg_req.wdata;
        default:                             ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data <= 32'h0000_0000;
    else if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        evg_pkg::OFS_LOAD_ANGLE_MAXIMUM:     rd_data <= {24'h00_0000, load_angle_maximum};
        evg_pkg::OFS_ENCODER_INPUT_CONFIG:   rd_data <= encoder_input_config;
        evg_pkg::OFS_EMF_VELOCITY_MINIMUM:   rd_data <= emf_velocity_minimum;
        evg_pkg::OFS_EMF_VELOCITY_SPAN:      rd_data <= emf_velocity_span;
        evg_pkg::OFS_ENCODER_IDLE_TIMEOUT:   rd_data <= encoder_idle_timeout;
        evg_pkg::OFS_VELOCITY_FILTER_CONFIG: rd_data <= velocity_filter_config;
        evg_pkg::OFS_SERIAL_REQUEST_PERIOD:  rd_data <= serial_request_period;
        evg_pkg::OFS_RAW_ENCODER_VELOCITY:   rd_data <= raw_encoder_velocity; // see [R7]
        evg_pkg::OFS_FILTERED_ENC_VELOCITY:  rd_data <= filtered_encoder_velocity; // see [R8]
        evg_pkg::OFS_ENCODER_STATUS:         rd_data <= {31'h0000_0000, idle_flag};
        default:                             rd_data <= 32'h0000_0000;
      endcase
    end
  end

  // Sticky idle flag, write one to clear; a new idle hit in the same cycle wins.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      idle_flag <= 1'b0;
    else if (idle_hit)
      idle_flag <= 1'b1;
    else if (wr_en && reg_req.addr == evg_pkg::OFS_ENCODER_STATUS
             && reg_req.wdata[evg_pkg::STATUS_IDLE_BIT])
      idle_flag <= 1'b0;
  end

  // Encoder pins are asynchronous; a level is accepted once stages two and three agree.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      a_sync  <= 3'h0;
      b_sync  <= 3'h0;
      a_q     <= 1'b0;
      b_q     <= 1'b0;
      ab_prev <= 2'h0;
    end
    else
    begin
      a_sync  <= {a_sync[1:0], enc_a};
      b_sync  <= {b_sync[1:0], enc_b};
      if (a_sync[1] == a_sync[2])
        a_q <= a_sync[2];
      if (b_sync[1] == b_sync[2])
        b_q <= b_sync[2];
      ab_prev <= {a_q, b_q};
    end
  end

  assign ab_edge = ({a_q, b_q} != ab_prev);
  assign step_up = ab_prev[0] ^ a_q;

  assign period_eff = encoder_input_config.abs_encoder ? velocity_filter_config.velocity_update_period
                    : (velocity_filter_config.velocity_update_period < evg_pkg::MIN_ABN_UPDATE_PERIOD)
                    ? evg_pkg::MIN_ABN_UPDATE_PERIOD
                    : velocity_filter_config.velocity_update_period; // see [R13]
  assign win_mag    = win_delta[16] ? 16'(-win_delta) : win_delta[15:0];
  assign abs_delta  = abs_pos - abs_prev;
  assign abs_mag    = abs_delta[31] ? -abs_delta : abs_delta;
  assign abs_mag_clip = (abs_mag > 32'h000f_ffff) ? 20'hf_ffff : abs_mag[19:0];
  assign idle_hit   = !ab_edge && encoder_idle_timeout != 32'h0000_0000
                    && gap == encoder_idle_timeout - 32'h0000_0001; // see [R16]

  // Edge counting window, gap timer and absolute position history.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      win_cnt   <= 16'h0000;
      win_delta <= 17'h0_0000;
      slow_mode <= 1'b1;
      gap       <= 32'h0000_0000;
      abs_prev  <= 32'h0000_0000;
    end
    else
    begin
      if (win_cnt >= period_eff - 16'h0001)
      begin
        win_cnt   <= 16'h0000;
        win_delta <= ab_edge ? (step_up ? 17'sh0_0001 : -17'sh0_0001) : 17'h0_0000;
        slow_mode <= win_mag < evg_pkg::LOW_SPEED_EDGES;
      end
      else
      begin
        win_cnt <= win_cnt + 16'h0001;
        if (ab_edge)
          win_delta <= step_up ? win_delta + 17'sh0_0001 : win_delta - 17'sh0_0001;
      end
      if (ab_edge)
        gap <= 32'h0000_0000;
      else if (gap != 32'hffff_ffff)
        gap <= gap + 32'h0000_0001;
      if (abs_pos_valid)
        abs_prev <= abs_pos;
    end
  end

  // Velocity division jobs: the latest request replaces one still waiting.
  always_comb
  begin
    new_job = 1'b0;
    new_num = '0;
    new_den = '0;
    new_neg = 1'b0;
    if (encoder_input_config.abs_encoder)
    begin
      if (abs_pos_valid)
      begin
        new_job = 1'b1;
        new_num = DIV_W'(abs_mag_clip) * evg_pkg::CLK_HZ_W48;
        new_den = DIV_W'(serial_request_period); // see [R14]
        new_neg = abs_delta[31];
      end
    end
    else if (win_cnt >= period_eff - 16'h0001 && win_mag >= evg_pkg::LOW_SPEED_EDGES)
    begin
      new_job = 1'b1;
      new_num = DIV_W'(win_mag) * evg_pkg::CLK_HZ_W48; // see [R13]
      new_den = DIV_W'(period_eff);
      new_neg = win_delta[16];
    end
    else if (ab_edge && slow_mode)
    begin
      new_job = 1'b1;
      new_num = evg_pkg::CLK_HZ_W48; // see [R15]
      new_den = DIV_W'({1'b0, gap}) + DIV_W'(1);
      new_neg = !step_up;
    end
  end

  assign mean_abs      = filtered_encoder_velocity[31] ? 32'(-filtered_encoder_velocity)
                       : filtered_encoder_velocity; // see [R5]
  assign upper_edge    = {1'b0, emf_velocity_minimum} + {1'b0, emf_velocity_span};
  assign linear_region = mean_abs > emf_velocity_minimum && {1'b0, mean_abs} <= upper_edge;

  assign div_start = (seq == evg_pkg::SEQ_IDLE) && !div_busy
                   && (vel_pend || (encoder_input_config.emf_comp_enable && linear_region));
  assign div_num   = vel_pend ? vel_num
                   : DIV_W'(load_angle_maximum) * DIV_W'(mean_abs - emf_velocity_minimum); // see [R17]
  assign div_den   = vel_pend ? vel_den : DIV_W'(emf_velocity_span);

  evg_divider #(
    .W (DIV_W)
  ) u_divider (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .start   (div_start),
    .num     (div_num),
    .den     (div_den),
    .busy    (div_busy),
    .done    (div_done),
    .quot    (div_quot)
  );

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vel_pend <= 1'b0;
      vel_num  <= '0;
      vel_den  <= '0;
      vel_neg  <= 1'b0;
    end
    else if (new_job)
    begin
      vel_pend <= 1'b1;
      vel_num  <= new_num;
      vel_den  <= new_den;
      vel_neg  <= new_neg;
    end
    else if (idle_hit || div_start)
      vel_pend <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      seq <= evg_pkg::SEQ_IDLE;
    else
    begin
      unique case (seq)
        evg_pkg::SEQ_IDLE:  if (div_start) seq <= vel_pend ? evg_pkg::SEQ_VEL : evg_pkg::SEQ_GAMMA;
        evg_pkg::SEQ_VEL:   if (div_done) seq <= evg_pkg::SEQ_IDLE;
        evg_pkg::SEQ_GAMMA: if (div_done) seq <= evg_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Raw velocity saturates at the largest positive magnitude; an idle hit forces zero.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      raw_encoder_velocity <= 32'h0000_0000;
    else if (idle_hit)
      raw_encoder_velocity <= 32'h0000_0000; // see [R16]
    else if (div_done && seq == evg_pkg::SEQ_VEL)
    begin
      if (div_quot > DIV_W'(32'h7fff_ffff))
        raw_encoder_velocity <= vel_neg ? 32'h8000_0001 : 32'h7fff_ffff;
      else
        raw_encoder_velocity <= vel_neg ? -div_quot[31:0] : div_quot[31:0]; // see [R7]
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      gamma_lin <= 8'h00;
    else if (div_done && seq == evg_pkg::SEQ_GAMMA)
      gamma_lin <= (div_quot > DIV_W'(load_angle_maximum)) ? load_angle_maximum : div_quot[7:0]; // see [R17]
  end

  assign wait_eff = encoder_input_config.abs_encoder ? serial_request_period // see [R11]
                  : {24'h00_0000, velocity_filter_config.filter_sample_wait}; // see [R9]

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_cnt                  <= 32'h0000_0000;
      filtered_encoder_velocity <= 32'h0000_0000;
    end
    else if (wait_cnt >= wait_eff)
    begin
      wait_cnt                  <= 32'h0000_0000;
      filtered_encoder_velocity <= filtered_encoder_velocity
                                 - (filtered_encoder_velocity >>> velocity_filter_config.filter_exponent)
                                 + (raw_encoder_velocity >>> velocity_filter_config.filter_exponent); // see [R12]
    end
    else
      wait_cnt <= wait_cnt + 32'h0000_0001;
  end

  // The linear value may lag one division behind a change of the filtered velocity.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      load_angle <= 8'h00;
    else if (!encoder_input_config.emf_comp_enable)
      load_angle <= 8'h00; // see [R2]
    else if (mean_abs <= emf_velocity_minimum)
      load_angle <= 8'h00; // see [R4]
    else if ({1'b0, mean_abs} > upper_edge)
      load_angle <= load_angle_maximum; // see [R3] [R4]
    else
      load_angle <= (gamma_lin > load_angle_maximum) ? load_angle_maximum : gamma_lin; // see [R8] [R4]
  end

  // Angle wraps modulo one electrical turn; software keeps lag plus load below 180 degrees.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      comp_angle <= '0;
    else if (filtered_encoder_velocity[31])
      comp_angle <= commut_angle - ANGLE_W'(load_angle); // see [R1] [R6]
    else
      comp_angle <= commut_angle + ANGLE_W'(load_angle); // see [R1]
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      encoder_idle_event <= 1'b0;
    else
      encoder_idle_event <= idle_hit; // see [R16]
  end

endmodule : evg_emf_comp

// file: testbench/evg_emf_comp_asserts.sv
`timescale 1ns/1ps
module evg_emf_comp_asserts #(
  parameter int unsigned ANGLE_W = 10
) (
  input wire logic                  sys_clk,
  input wire logic                  arst_n,
  input wire evg_pkg::evg_reg_req_t reg_req,
  input wire logic [31:0]           rd_data,
  input wire logic                  enc_a,
  input wire logic                  enc_b,
  input wire logic                  abs_pos_valid,
  input wire logic [31:0]           abs_pos,
  input wire logic [ANGLE_W-1:0]    commut_angle,
  input wire logic [ANGLE_W-1:0]    comp_angle,
  input wire logic [7:0]            load_angle,
  input wire logic                  encoder_idle_event
);
  logic [7:0]  max_q;
  logic [5:0]  max_age;
  logic [3:0]  en_hist;
  logic [31:0] tmo_q;
  logic [31:0] quiet;
  logic [1:0]  ab_q;

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // Shadows of the registers whose effect shows at the ports.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      max_q   <= 8'hff;
      max_age <= 6'h00;
      en_hist <= 4'h0;
      tmo_q   <= 32'h0;
    end
    else
    begin
      if (reg_req.wr && reg_req.addr == evg_pkg::OFS_LOAD_ANGLE_MAXIMUM)
        max_q <= reg_req.wdata[7:0];
      if (reg_req.wr && reg_req.addr == evg_pkg::OFS_ENCODER_IDLE_TIMEOUT)
        tmo_q <= reg_req.wdata;
      max_age <= (reg_req.wr && reg_req.addr == evg_pkg::OFS_LOAD_ANGLE_MAXIMUM) ? 6'h00
                 : max_age + 6'(max_age != 6'h3f);
      en_hist <= {en_hist[2:0], (reg_req.wr && reg_req.addr == evg_pkg::OFS_ENCODER_INPUT_CONFIG)
                 ? reg_req.wdata[0] : en_hist[0]};
    end
  end

  // Cycles since the last pin change.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ab_q  <= 2'b00;
      quiet <= 32'h0;
    end
    else
    begin
      ab_q  <= {enc_a, enc_b};
      quiet <= ({enc_a, enc_b} != ab_q) ? 32'h0 : quiet + 32'(quiet != 32'hffff_ffff);
    end
  end

  sequence s_rd_max;
    reg_req.rd && reg_req.addr == evg_pkg::OFS_LOAD_ANGLE_MAXIMUM;
  endsequence

  a_max_readback: assert property (s_rd_max |=> rd_data == {24'h0, max_q})
    else $error("load angle maximum read back wrong");
  a_unmapped_zero: assert property (reg_req.rd && !(reg_req.addr inside {8'h07, 8'h1c, 8'h60, 8'h61,
    8'h62, 8'h63, 8'h65, 8'h66, 8'h70, 8'h71}) |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_rd_holds: assert property (!reg_req.rd |=> $stable(rd_data))
    else $error("read data changed without a read");
  a_load_bounded: assert property (max_age == 6'h3f |-> load_angle <= max_q)
    else $error("load angle above maximum");
  a_load_disabled: assert property (en_hist == 4'h0 |-> load_angle == 8'h00)
    else $error("load angle nonzero while disabled");
  a_comp_plain: assert property (load_angle == 8'h00 && $past(load_angle) == 8'h00
    |-> comp_angle == $past(commut_angle))
    else $error("angle changed with zero load angle");
  a_comp_offset: assert property ($stable(load_angle) |-> comp_angle == $past(commut_angle)
    + ANGLE_W'(load_angle) || comp_angle == $past(commut_angle) - ANGLE_W'(load_angle))
    else $error("angle offset is not the load angle");
  a_event_pulse: assert property (encoder_idle_event |=> !encoder_idle_event)
    else $error("idle event longer than one cycle");
  a_event_quiet: assert property (encoder_idle_event |-> quiet >= tmo_q)
    else $error("idle event before timeout");
endmodule : evg_emf_comp_asserts

bind evg_emf_comp evg_emf_comp_asserts #(.ANGLE_W(ANGLE_W)) chk_u (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req), .rd_data(rd_data), .enc_a(enc_a),
  .enc_b(enc_b), .abs_pos_valid(abs_pos_valid), .abs_pos(abs_pos), .commut_angle(commut_angle),
  .comp_angle(comp_angle), .load_angle(load_angle), .encoder_idle_event(encoder_idle_event)
);

// file: testbench/evg_enc_model.sv
`timescale 1ns/1ps
module evg_enc_model #(
  parameter int unsigned STEP = 16
) (
  input  wire logic sys_clk,
  input  wire logic run,
  input  wire logic fwd,
  output wire logic enc_a,
  output wire logic enc_b
);
  logic [1:0]  ph;
  int unsigned cnt;

  initial
  begin
    ph  = 2'b00;
    cnt = 0;
  end

  // A steady step interval keeps the edge count per velocity window exact.
  always @(posedge sys_clk)
  begin
    if (run)
    begin
      cnt <= (cnt == STEP - 1) ? 0 : cnt + 1;
      if (cnt == STEP - 1)
        ph <= fwd ? ph + 2'b01 : ph - 2'b01;
    end
  end

  // Gray order, A leading when moving forward.
  assign enc_a = ph[0] ^ ph[1];
  assign enc_b = ph[1];
endmodule : evg_enc_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic                  sys_clk;
  logic                  arst_n;
  evg_pkg::evg_reg_req_t reg_req;
  logic [31:0]           rd_data;
  logic                  enc_a;
  logic                  enc_b;
  logic                  enc_run;
  logic                  enc_fwd;
  logic [9:0]            commut_angle;
  logic [9:0]            comp_angle;
  logic [7:0]            load_angle;
  logic                  encoder_idle_event;
  logic [31:0]           val;
  logic                  abs_v = 1'b0;
  logic [31:0]           abs_p = 32'h0;
  logic [7:0]            zlist [7] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66};
  int                    error_cnt;
  int                    tests_run;
  int                    n;

  evg_emf_comp dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req), .rd_data(rd_data), .enc_a(enc_a),
    .enc_b(enc_b), .abs_pos_valid(abs_v), .abs_pos(abs_p), .commut_angle(commut_angle),
    .comp_angle(comp_angle), .load_angle(load_angle), .encoder_idle_event(encoder_idle_event)
  );
  evg_enc_model #(.STEP(16)) enc_u (
    .sys_clk(sys_clk), .run(enc_run), .fwd(enc_fwd), .enc_a(enc_a), .enc_b(enc_b)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic signed [31:0] got);
    tests_run++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1))
    begin
      error_cnt++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    reg_req.wr    <= 1'b1;
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    reg_req.addr <= a;
    reg_req.rd   <= 1'b1;
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1;
    val = rd_data;
    chk(nm, exp, val);
    @(posedge sys_clk);
  endtask : rchk

  task automatic idle(input int cyc);
    repeat (cyc) @(posedge sys_clk);
    #1;
  endtask : idle

  task automatic report_and_stop;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #600us;
    error_cnt++;
    $display("[ERR] watchdog expected end seen hang");
    report_and_stop();
  end

  initial
  begin
    reg_req      = '0;
    commut_angle = 10'h000;
    enc_run      = 1'b0;
    enc_fwd      = 1'b1;
    arst_n       = 1'b0;
    error_cnt    = 0;
    tests_run    = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rchk("max_reset", evg_pkg::OFS_LOAD_ANGLE_MAXIMUM, 32'h0000_00ff);
    foreach (zlist[i])
      rchk("zero_reset", zlist[i], 32'h0);
    wr(evg_pkg::OFS_LOAD_ANGLE_MAXIMUM, 32'hffff_ff40);
    rchk("max_rw", evg_pkg::OFS_LOAD_ANGLE_MAXIMUM, 32'h0000_0040);
    wr(evg_pkg::OFS_RAW_ENCODER_VELOCITY, 32'h1234_5678);
    rchk("raw_ro", evg_pkg::OFS_RAW_ENCODER_VELOCITY, 32'h0);
    // Wait 40 (above 32), exponent 2, period 256.
    wr(evg_pkg::OFS_VELOCITY_FILTER_CONFIG, 32'h0100_0228);
    rchk("filt_cfg", evg_pkg::OFS_VELOCITY_FILTER_CONFIG, 32'h0100_0228);
    wr(evg_pkg::OFS_EMF_VELOCITY_SPAN, 32'h00be_bc20);
    commut_angle <= 10'h100;
    enc_run      <= 1'b1;
    idle(4000);
    // Sixteen edges per 256-cycle window.
    rchk("raw_fwd", evg_pkg::OFS_RAW_ENCODER_VELOCITY, 32'h005f_5e10);
    rchk("filt_probe", evg_pkg::OFS_FILTERED_ENC_VELOCITY, 32'h005f_5e10);
    chk_rng("filt_fwd", 6249990, 6250003, val);
    chk("load_off", 32'(load_angle), 32'h0);
    chk("comp_off", 32'(comp_angle), 32'h100);
    // Maximum 0x40 keeps lag plus load below 180 degrees.
    wr(evg_pkg::OFS_ENCODER_INPUT_CONFIG, 32'h1);
    idle(300);
    chk("load_lin", 32'(load_angle), 32'h20);
    chk("comp_lin", 32'(comp_angle), 32'h120);
    wr(evg_pkg::OFS_EMF_VELOCITY_MINIMUM, 32'h005f_5e13);
    idle(300);
    chk("load_min", 32'(load_angle), 32'h0);
    wr(evg_pkg::OFS_EMF_VELOCITY_MINIMUM, 32'h0);
    wr(evg_pkg::OFS_EMF_VELOCITY_SPAN, 32'h0000_03e8);
    idle(300);
    chk("load_sat", 32'(load_angle), 32'h40);
    chk("comp_sat", 32'(comp_angle), 32'h140);
    wr(evg_pkg::OFS_LOAD_ANGLE_MAXIMUM, 32'h0000_00ff);
    enc_fwd <= 1'b0;
    idle(6000);
    rchk("raw_rev", evg_pkg::OFS_RAW_ENCODER_VELOCITY, 32'hffa0_a1f0);
    chk("load_rev", 32'(load_angle), 32'hff);
    chk("comp_rev", 32'(comp_angle), 32'h001);
    wr(evg_pkg::OFS_ENCODER_IDLE_TIMEOUT, 32'd500);
    enc_run <= 1'b0;
    n = 0;
    while (encoder_idle_event !== 1'b1 && n < 1000)
    begin
      idle(1);
      n++;
    end
    chk_rng("idle_delay", 480, 530, n);
    rchk("raw_idle", evg_pkg::OFS_RAW_ENCODER_VELOCITY, 32'h0);
    rchk("status_set", evg_pkg::OFS_ENCODER_STATUS, 32'h1);
    wr(evg_pkg::OFS_ENCODER_STATUS, 32'h1);
    rchk("status_clr", evg_pkg::OFS_ENCODER_STATUS, 32'h0);
    idle(4000);
    chk("load_stop", 32'(load_angle), 32'h0);
    chk("comp_stop", 32'(comp_angle), 32'h100);
    wr(evg_pkg::OFS_SERIAL_REQUEST_PERIOD, 32'd100);
    wr(evg_pkg::OFS_ENCODER_INPUT_CONFIG, 32'h3);
    abs_p <= 32'h10;
    abs_v <= 1'b1;
    idle(1);
    abs_v <= 1'b0;
    idle(60);
    rchk("raw_abs", evg_pkg::OFS_RAW_ENCODER_VELOCITY, 32'h00f4_2400);
    report_and_stop();
  end
endmodule : tb
